// ==== hdl/scdf_filter.sv ====
// Switch change debounce filter: per-input stability filter ahead of the
// interrupt logic, plus an unfiltered path for the shared group threshold.
// Assumes cycleDone pulses for one clock when a detection cycle's results
// are valid on inStatus and groupStatus, all inputs synchronous to clk.
//
// What this block does
// - Four debounce schemes picked by software field
// - Least strict scheme fires on any crossing
// - Others need 2, 3 or 4 stable cycles
// - Code 11 needs four stable cycles
// - Stability judged on threshold status, not voltage
// - Baseline status stored after first detection cycle
// - Scheme applies to every enabled input
// - Counters clear when run bit drops
// - Reset selects fire-on-every-crossing scheme
// - Shared group threshold events are never debounced
// - Rising, falling or both edges qualify crossings
module scdf_filter
(
  input  wire logic                                clk,
  input  wire logic                                reset,
  input  wire logic                                runEnable,
  input  wire logic [1:0]                          debounce_select,
  input  wire logic                                cycleDone,
  input  wire logic [scdf_pkg::INPUT_COUNT-1:0]    inStatus,
  input  wire logic [scdf_pkg::INPUT_COUNT-1:0]    inEnable,
  input  wire logic [scdf_pkg::INPUT_COUNT-1:0]    riseEnable,
  input  wire logic [scdf_pkg::INPUT_COUNT-1:0]    fallEnable,
  input  wire logic                                groupStatus,
  input  wire logic                                groupEnable,
  input  wire logic                                groupRiseEnable,
  input  wire logic                                groupFallEnable,
  output logic      [scdf_pkg::INPUT_COUNT-1:0]    changeFlags,
  output logic      [scdf_pkg::INPUT_COUNT-1:0]    baselineStatus,
  output logic                                     groupChange,
  output logic                                     switch_change_interrupt,
  output logic      [1:0]                          activeSelect
);

  //////////////////////////////////////////////////////////////////////////////
  // Timing, from the edge that takes cycleDone (edge 0):
  //   after edge 0  lane count, baseline and fire registered;
  //                 baselineStatus already shows an adopted status
  //   after edge 1  changeFlags, groupChange and interrupt high one clock
  //   after edge 2  pulses low again unless a later cycle fired
  // The extra output stage costs one clock of latency; it buys one word of
  // flags per detection cycle, aligned with the group path, so the
  // interrupt logic never sees half of a cycle's changes.
  //
  // Limits a user must know:
  //   - A scheme written while running is ignored, not queued; it loads
  //     only while the run bit is low
  //   - Dropping the run bit also forgets every baseline, so the first
  //     detection cycle after a restart stores and never fires
  //   - A disabled input is frozen with its count and baseline, and picks
  //     up where it stopped once enabled again
  //   - A cycleDone held high for several clocks counts once per clock
  //   - An edge masked off by riseEnable or fallEnable still moves the
  //     baseline, so the opposite edge is judged against the new status
  //   - The group path has no count, only an edge compare with the last
  //     taken sample, and is cleared with the lanes
  //   - activeSelect shows the scheme in use, not the last one written

  //////////////////////////////////////////////////////////////////////////////
  // Debounce selection register
  scdf_pkg::scdf_deb_t                 sel_q;
  scdf_pkg::scdf_deb_t                 sel_d;
  logic [scdf_pkg::COUNT_W-1:0]        need;
  logic                                clearAll;

  // Selection changes only while stopped, so a running count never
  // sees its target move under it.
  always_comb
  begin
    sel_d = sel_q;
    if (!runEnable)
    begin
      sel_d = scdf_pkg::scdf_deb_t'(debounce_select);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_q <= scdf_pkg::DEB_RESET;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // Stable cycles required by the chosen scheme
  always_comb
  begin
    unique case (sel_q)
      scdf_pkg::DEB_ANY:   need = scdf_pkg::NEED_ANY;
      scdf_pkg::DEB_TWO:   need = scdf_pkg::NEED_TWO;
      scdf_pkg::DEB_THREE: need = scdf_pkg::NEED_THREE;
      scdf_pkg::DEB_FOUR:  need = scdf_pkg::NEED_FOUR;
    endcase
  end

  // Stopping the run clears every lane
  assign clearAll = !runEnable;

  //////////////////////////////////////////////////////////////////////////////
  // Per-input lanes, one filter each
  logic [scdf_pkg::INPUT_COUNT-1:0]    laneFire;

  generate
    for (genvar i = 0; i < scdf_pkg::INPUT_COUNT; i++)
    begin : gLane
      scdf_lane_if link ();

      // Only the threshold status bit is judged, never a raw level
      assign link.sample = cycleDone;
      assign link.clear  = clearAll;
      assign link.status = inStatus[i];
      assign link.enable = inEnable[i];
      assign link.riseEn = riseEnable[i];
      assign link.fallEn = fallEnable[i];
      assign link.need   = need;
      assign laneFire[i]       = link.fire;
      assign baselineStatus[i] = link.baseline;

      scdf_lane uLane
      (
        .clk   (clk),
        .reset (reset),
        .port  (link.lane)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Shared group threshold: straight edge compare, no stability count
  logic grpStored_q;
  logic grpStored_d;
  logic grpPrev_q;
  logic grpPrev_d;
  logic grpFire_q;
  logic grpFire_d;

  always_comb
  begin
    grpStored_d = grpStored_q;
    grpPrev_d   = grpPrev_q;
    grpFire_d   = 1'b0;
    if (clearAll)
    begin
      grpStored_d = 1'b0;
    end
    else if (cycleDone && groupEnable)
    begin
      grpStored_d = 1'b1;
      grpPrev_d   = groupStatus;
      // An enabled edge fires on the first differing cycle whatever the scheme
      if (grpStored_q && (groupStatus != grpPrev_q))
      begin
        grpFire_d = groupStatus ? groupRiseEnable : groupFallEnable;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      grpStored_q <= 1'b0;
      grpPrev_q   <= 1'b0;
      grpFire_q   <= 1'b0;
    end
    else
    begin
      grpStored_q <= grpStored_d;
      grpPrev_q   <= grpPrev_d;
      grpFire_q   <= grpFire_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs toward the interrupt request logic
  logic [scdf_pkg::INPUT_COUNT-1:0] flags_q;
  logic [scdf_pkg::INPUT_COUNT-1:0] flags_d;
  logic                             grpOut_q;
  logic                             grpOut_d;
  logic                             irq_q;
  logic                             irq_d;

  // One registered stage so all change outputs line up in the same cycle
  always_comb
  begin
    flags_d  = laneFire;
    grpOut_d = grpFire_q;
    irq_d    = (|laneFire) | grpFire_q;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_q  <= '0;
      grpOut_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      flags_q  <= flags_d;
      grpOut_q <= grpOut_d;
      irq_q    <= irq_d;
    end
  end

  assign changeFlags             = flags_q;
  assign groupChange             = grpOut_q;
  assign switch_change_interrupt = irq_q;
  assign activeSelect            = sel_q;

endmodule

// ==== hdl/scdf_lane.sv ====
// One input's debounce state: stored baseline, stability count, fire pulse.
// Assumes sample marks one finished detection cycle and lasts one clock.
module scdf_lane
(
  input  wire logic   clk,
  input  wire logic   reset,
  scdf_lane_if.lane   port
);

  logic                         stored_q;
  logic                         stored_d;
  logic                         base_q;
  logic                         base_d;
  logic [scdf_pkg::COUNT_W-1:0] count_q;
  logic [scdf_pkg::COUNT_W-1:0] count_d;
  logic                         fire_q;
  logic                         fire_d;
  logic [scdf_pkg::COUNT_W-1:0] countNext;

  //////////////////////////////////////////////////////////////////////////////
  // Next state of baseline and counter
  always_comb
  begin
    stored_d  = stored_q;
    base_d    = base_q;
    count_d   = count_q;
    fire_d    = 1'b0;
    countNext = count_q + 3'h1;
    if (port.clear)
    begin
      // Run stopped: counts drop to zero, baseline taken afresh later
      stored_d = 1'b0;
      count_d  = scdf_pkg::COUNT_RESET;
    end
    else if (port.sample && port.enable)
    begin
      if (!stored_q)
      begin
        // First cycle only stores the baseline, never fires
        stored_d = 1'b1;
        base_d   = port.status;
      end
      else if (port.status == base_q)
      begin
        // Status reverted or never moved: restart the count
        count_d = scdf_pkg::COUNT_RESET;
      end
      else if (countNext >= port.need)
      begin
        // Held long enough: adopt new status, fire once if that edge is enabled
        base_d  = port.status;
        count_d = scdf_pkg::COUNT_RESET;
        fire_d  = port.status ? port.riseEn : port.fallEn;
      end
      else
      begin
        count_d = countNext;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stored_q <= 1'b0;
      base_q   <= 1'b0;
      count_q  <= scdf_pkg::COUNT_RESET;
      fire_q   <= 1'b0;
    end
    else
    begin
      stored_q <= stored_d;
      base_q   <= base_d;
      count_q  <= count_d;
      fire_q   <= fire_d;
    end
  end

  assign port.baseline = base_q;
  assign port.fire     = fire_q;

endmodule

// ==== hdl/scdf_lane_if.sv ====
// Carrier between the filter top and one per-input lane.
// Assumes the top drives the control side and the lane answers on its own modport.
interface scdf_lane_if;

  logic                               sample;
  logic                               clear;
  logic                               status;
  logic                               enable;
  logic                               riseEn;
  logic                               fallEn;
  logic [scdf_pkg::COUNT_W-1:0]       need;
  logic                               baseline;
  logic                               fire;

  modport ctrl
  (
    output sample,
    output clear,
    output status,
    output enable,
    output riseEn,
    output fallEn,
    output need,
    input  baseline,
    input  fire
  );

  modport lane
  (
    input  sample,
    input  clear,
    input  status,
    input  enable,
    input  riseEn,
    input  fallEn,
    input  need,
    output baseline,
    output fire
  );

endinterface

// ==== hdl/scdf_pkg.sv ====
// Constants shared by the switch change debounce filter and its lanes.
// Assumes one clock; detection cycles are marked by a strobe from the sequencer.
package scdf_pkg;

  // Number of monitored switch inputs
  localparam int unsigned INPUT_COUNT = 24;

  // Width of the per-input stability counter
  localparam int unsigned COUNT_W = 3;

  // Debounce selection codes
  typedef enum logic [1:0]
  {
    DEB_ANY   = 2'h0,
    DEB_TWO   = 2'h1,
    DEB_THREE = 2'h2,
    DEB_FOUR  = 2'h3
  } scdf_deb_t;

  // Stable cycles needed per debounce selection
  localparam logic [COUNT_W-1:0] NEED_ANY   = 3'h1;
  localparam logic [COUNT_W-1:0] NEED_TWO   = 3'h2;
  localparam logic [COUNT_W-1:0] NEED_THREE = 3'h3;
  localparam logic [COUNT_W-1:0] NEED_FOUR  = 3'h4;

  // Reset values
  localparam scdf_deb_t          DEB_RESET   = DEB_ANY;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 3'h0;

endpackage

// ==== sim/scdf_filter_asserts.sv ====
// Timing checks on the debounce filter ports.
// Assumes one clock and the synchronous active-high reset.
module scdf_filter_asserts
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        runEnable,
  input  wire logic [1:0]  debounce_select,
  input  wire logic        cycleDone,
  input  wire logic [23:0] riseEnable,
  input  wire logic [23:0] fallEnable,
  input  wire logic [23:0] changeFlags,
  input  wire logic [23:0] baselineStatus,
  input  wire logic        groupChange,
  input  wire logic        switch_change_interrupt,
  input  wire logic [1:0]  activeSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Reset state
  a_reset_default: assert property (
    disable iff (1'b0) reset |=> activeSelect == 2'h0 && changeFlags == '0)
    else $error("select or flags not cleared by reset");
  // Interrupt is the OR of every lane flag and the group change
  a_irq_or_flags: assert property (
    switch_change_interrupt == ((|changeFlags) || groupChange))
    else $error("interrupt differs from OR of flags and group change");
  a_flag_once: assert property (changeFlags[0] |=> !changeFlags[0])
    else $error("flag held more than one cycle");
  // Fires only from a counted cycle two edges earlier
  a_fire_cause: assert property (
    ((|changeFlags) || groupChange) |-> $past(cycleDone, 2) && $past(runEnable, 2))
    else $error("fire without a taken detection cycle");
  a_stop_quiet: assert property (!runEnable [*3] |-> changeFlags == '0 && !groupChange)
    else $error("fire while stopped");
  // Baseline moves only on a detection cycle or a stop
  a_base_cause: assert property (
    !$stable(baselineStatus) |-> $past(cycleDone) || !$past(runEnable))
    else $error("baseline moved without cause");
  // Flag only for a baseline that moved in a direction enabled at decision
  a_flag_edge: assert property (
    changeFlags[0] |-> $past(baselineStatus[0]) != $past(baselineStatus[0], 2) &&
      ($past(baselineStatus[0]) ? $past(riseEnable[0], 2) : $past(fallEnable[0], 2)))
    else $error("flag without qualified baseline change");
  // Selection loads only while stopped
  a_sel_frozen: assert property (runEnable && $past(runEnable) |-> $stable(activeSelect))
    else $error("selection changed while running");
  a_sel_load: assert property (
    !reset && !runEnable |=> activeSelect == $past(debounce_select))
    else $error("selection not loaded while stopped");
endmodule

bind scdf_filter scdf_filter_asserts scdf_filter_asserts_i (.clk, .reset, .runEnable,
  .debounce_select, .cycleDone, .riseEnable, .fallEnable, .changeFlags, .baselineStatus,
  .groupChange, .switch_change_interrupt, .activeSelect);

// ==== sim/scdf_filter_tb.sv ====
// Self-checking bench for the switch change debounce filter.
// Assumes the sampler model and the bound checker are compiled alongside.
module scdf_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] EN = 24'hFF_FFFD;
  localparam logic [23:0] V  = 24'h81_0003;
  typedef struct {logic [1:0] sel; int need;} scdf_row_t;
  scdf_row_t   rows [4] = '{'{2'h0, 1}, '{2'h1, 2}, '{2'h2, 3}, '{2'h3, 4}};
  logic        clk, reset, runEnable, cycleDone, groupStatus, groupChange, irq;
  logic        groupEnable, groupRiseEnable, groupFallEnable;
  logic [1:0]  debounce_select, activeSelect;
  logic [23:0] inStatus, inEnable, riseEnable, fallEnable, changeFlags, baselineStatus;
  int          miscompares = 0;
  int          tests_run = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design under test and the switch sampler feeding it
  scdf_filter scdf_filter_i (.clk, .reset, .runEnable, .debounce_select, .cycleDone,
    .inStatus, .inEnable, .riseEnable, .fallEnable, .groupStatus, .groupEnable,
    .groupRiseEnable, .groupFallEnable, .changeFlags, .baselineStatus,
    .groupChange, .switch_change_interrupt(irq), .activeSelect);
  scdf_switch_model scdf_switch_model_i (.clk, .cycleDone, .inStatus, .groupStatus);

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Stop, load a scheme, run again; stopping also clears all counts
  task automatic restart(input logic [1:0] s);
    @(posedge clk);
    runEnable       <= 1'b0;
    debounce_select <= s;
    repeat (2) @(posedge clk);
    runEnable <= 1'b1;
    #1 chk(activeSelect, s);
  endtask

  // n results; baseline and pulses stand one edge after the last result,
  // and the pulses are gone again one edge later
  task automatic step(input logic [23:0] v, input logic g, input int n,
                      input logic [23:0] ef, input logic [23:0] eb, input logic eg);
    scdf_switch_model_i.detect(v, g, n);
    @(posedge clk);
    #1 chk(baselineStatus, eb);
    chk({groupChange, irq, changeFlags}, {eg, (|ef) | eg, ef});
    @(posedge clk);
    #1 chk({groupChange, irq, changeFlags}, '0);
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1;
    runEnable = 1'b0;
    debounce_select = 2'h3;
    inEnable = EN;
    riseEnable = '1;
    fallEnable = '1;
    groupEnable = 1'b1;
    groupRiseEnable = 1'b1;
    groupFallEnable = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1 chk({activeSelect, changeFlags, baselineStatus}, '0);
    // Each scheme fires exactly at its count, the firing cycle after a pause
    foreach (rows[i])
    begin
      restart(rows[i].sel);
      step(0, 0, 1, 0, 0, 0);
      if (rows[i].need > 1) step(V, 0, rows[i].need - 1, 0, 0, 0);
      step(V, 0, 1, V & EN, V & EN, 0);
    end
    // Reversion restarts the count; a masked edge still moves the baseline
    @(posedge clk);
    riseEnable <= 24'hFF_0000;
    fallEnable <= 24'h00_FFFF;
    restart(2'h1);
    step(0, 0, 1, 0, 0, 0);
    step(V, 0, 1, 0, 0, 0);
    step(0, 0, 1, 0, 0, 0);
    step(V, 0, 1, 0, 0, 0);
    step(V, 0, 1, V & EN & 24'hFF_0000, V & EN, 0);
    step(0, 0, 2, V & EN & 24'h00_FFFF, 0, 0);
    @(posedge clk);
    riseEnable <= '1;
    fallEnable <= '1;
    // Stop mid count clears it; group change is never filtered
    restart(2'h3);
    step(0, 0, 1, 0, 0, 0);
    step(V, 0, 3, 0, 0, 0);
    restart(2'h3);
    step(V, 0, 1, 0, V & EN, 0);
    step(V, 1, 1, 0, V & EN, 1);
    // Group edges are qualified and the group enable gates sampling
    @(posedge clk);
    groupFallEnable <= 1'b0;
    step(V, 0, 1, 0, V & EN, 0);
    @(posedge clk);
    groupEnable <= 1'b0;
    step(V, 1, 1, 0, V & EN, 0);
    // Selection ignored while running
    @(posedge clk);
    debounce_select <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk(activeSelect, 2'h3);
    // Reset in mid-run falls back to firing on every crossing
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1 chk({activeSelect, changeFlags, baselineStatus}, '0);
    step(0, 0, 1, 0, 0, 0);
    step(V, 0, 1, V & EN, V & EN, 0);
    end_of_test;
  end

  // Watchdog well beyond the roughly 150 cycles the tests take
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
endmodule

// ==== sim/scdf_switch_model.sv ====
// Switch sampler model: hands finished detection results to the filter.
// Assumes the filter takes cycleDone at the rising edge of clk.
module scdf_switch_model
(
  input  wire logic        clk,
  output logic             cycleDone,
  output logic [23:0]      inStatus,
  output logic             groupStatus
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Idle between results
  initial
  begin
    cycleDone   = 1'b0;
    inStatus    = 24'h00_0000;
    groupStatus = 1'b0;
  end

  // n back-to-back results, then stale data shown inverted so it is not trusted
  task automatic detect(input logic [23:0] v, input logic g, input int n);
    @(posedge clk);
    cycleDone   <= 1'b1;
    inStatus    <= v;
    groupStatus <= g;
    repeat (n) @(posedge clk);
    cycleDone   <= 1'b0;
    inStatus    <= ~v;
    groupStatus <= ~g;
  endtask
endmodule
